// ---- tsi_i2c_slave.sv ----
/*
  Two-wire slave port of the touch expander: strap capture, start/stop
  detection, address match, acknowledge, random and sequential register
  reads and writes with pointer auto-increment and wrap.
  Assumes a register file outside: it answers reg_rd_data for
  reg_rd_addr combinationally and drains the write stream.
  Bus pins are open drain, resolved by the surroundings.
*/
`timescale 1ns/1ps
module tsi_i2c_slave
  import tsi_pkg::*;
#(
  parameter logic [7:0] LAST_REG_ADDR = 8'hff,
  parameter logic [7:0] NOINC_LO      = 8'hff,
  parameter logic [7:0] NOINC_HI      = 8'h00,
  parameter int         WR_DEPTH      = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // reset straps
  input  wire logic        iface_mode_strap,
  input  wire logic        bus_address_strap,
  output logic             spi_selected,
  // bus clock pin
  input  wire logic        scl_level,
  output logic             scl_value,
  output logic             scl_oe,
  // bus data pin
  input  wire logic        serial_data_line_level,
  output logic             serial_data_line_value,
  output logic             serial_data_line_oe,
  // register read port
  output logic [7:0]       reg_rd_addr,
  output logic             reg_rd_strobe,
  input  wire logic [7:0]  reg_rd_data,
  // register write stream
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data
);

  // edges must be seen well inside the shortest clock high time
  if (SYNC_LAT_CYC >= T_HIGH_CYC || SYNC_LAT_CYC >= T_SU_DAT_CYC) begin : g_bad_rate // RULE20
    $error("clock too slow for fast-mode bus");
  end

  // synchronised pins
  logic [3:0] pins_s;
  wire        mode_s;
  wire        addr_s;
  wire        scl_s;
  wire        sda_s;

  tsi_sync #(.WIDTH(4)) u_sync (
    .clk  (clk),
    .din  ({iface_mode_strap, bus_address_strap, scl_level, serial_data_line_level}),
    .dout (pins_s)
  ); // RULE23
  assign {mode_s, addr_s, scl_s, sda_s} = pins_s;

  // state
  tsi_state_t st_r, st_nxt;
  tsi_kind_t  kind_r, kind_nxt;
  logic [2:0] bitcnt_r, bitcnt_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic       sda_oe_r, sda_oe_nxt;
  logic       ack_on_r, ack_on_nxt;
  logic       rw_r, rw_nxt;
  logic       inc_en_r, inc_en_nxt;
  logic       pend_r, pend_nxt;
  logic       mack_ok_r, mack_ok_nxt;
  logic       rd_stb_nxt;
  logic       rd_stb_r;
  logic       load_tx;
  logic       spi_sel_r;
  logic       addr_sel_r;
  logic       scl_prev_r;
  logic       sda_prev_r;

  // write buffer
  tsi_stream_if #(.W(WR_WORD_W)) s_in ();
  tsi_stream_if #(.W(WR_WORD_W)) s_out ();

  tsi_fifo #(.WIDTH(WR_WORD_W), .DEPTH(WR_DEPTH)) u_fifo (
    .clk     (clk),
    .srst    (srst),
    .wr_side (s_in),
    .rd_side (s_out)
  );

  assign s_in.valid  = pend_r;
  assign s_in.data   = {ptr_r, wbyte_r};
  assign wr_valid    = s_out.valid;
  assign s_out.ready = wr_ready;
  assign wr_addr     = s_out.data[WR_WORD_W-1:BYTE_W];
  assign wr_data     = s_out.data[BYTE_W-1:0];

  // line events, both lines delayed alike so their order holds
  wire scl_rise  = scl_s & ~scl_prev_r; // RULE23
  wire scl_fall  = ~scl_s & scl_prev_r;
  wire start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s; // RULE6
  wire stop_det  = scl_s & scl_prev_r & ~sda_prev_r & sda_s; // RULE8
  wire i2c_on    = (spi_sel_r == STRAP_TWOWIRE);

  // decode of the byte completing on this rising edge
  wire [7:0] dev_addr  = addr_sel_r ? DEV_ADDR_A1 : DEV_ADDR_A0; // RULE2
  wire [7:0] rx_byte   = {rx_sh_r[6:0], sda_s}; // RULE13
  wire       byte_done = (st_r == ST_RX) && scl_rise && (bitcnt_r == BIT_LAST);
  wire       addr_match = (rx_byte[7:1] == dev_addr[7:1]);
  wire       in_noinc  = (rx_byte >= NOINC_LO) && (rx_byte <= NOINC_HI);
  wire [7:0] ptr_inc   = (ptr_r == LAST_REG_ADDR) ? PTR_WRAP : ptr_r + 8'h01; // RULE21
  wire       push      = s_in.valid & s_in.ready;

  // next state of the slave engine
  always_comb begin
    st_nxt      = st_r;
    kind_nxt    = kind_r;
    bitcnt_nxt  = bitcnt_r;
    rx_sh_nxt   = rx_sh_r;
    tx_sh_nxt   = tx_sh_r;
    ptr_nxt     = ptr_r;
    wbyte_nxt   = wbyte_r;
    sda_oe_nxt  = sda_oe_r;
    ack_on_nxt  = ack_on_r;
    rw_nxt      = rw_r;
    inc_en_nxt  = inc_en_r;
    pend_nxt    = pend_r;
    mack_ok_nxt = mack_ok_r;
    rd_stb_nxt  = 1'b0;
    load_tx     = 1'b0;
    // pending write enters the buffer, pointer moves only in increment ranges
    if (push) begin
      pend_nxt = 1'b0;
      if (inc_en_r) begin
        ptr_nxt = ptr_inc; // RULE18
      end
    end
    if (!i2c_on) begin
      st_nxt     = ST_IDLE; // RULE1
      sda_oe_nxt = 1'b0;
    end else if (start_det) begin
      st_nxt      = ST_RX; // RULE7
      kind_nxt    = K_DEV;
      bitcnt_nxt  = '0;
      sda_oe_nxt  = 1'b0;
      ack_on_nxt  = 1'b0;
      mack_ok_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt      = ST_IDLE; // RULE8 RULE9 RULE10
      sda_oe_nxt  = 1'b0;
      ack_on_nxt  = 1'b0;
      mack_ok_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_RX: begin
          if (scl_rise) begin
            rx_sh_nxt  = rx_byte; // RULE13 RULE14
            bitcnt_nxt = bitcnt_r + 3'h1;
            if (bitcnt_r == BIT_LAST) begin
              st_nxt = ST_ACK;
              case (kind_r)
                K_DEV: begin
                  rw_nxt = (rx_byte[0] == RW_READ); // RULE3
                  if (!addr_match) begin
                    st_nxt = ST_IGNORE; // RULE5
                  end
                end
                K_REG: begin
                  ptr_nxt    = rx_byte; // RULE24
                  inc_en_nxt = ~in_noinc; // RULE18 RULE19
                end
                default: begin
                  wbyte_nxt = rx_byte;
                  pend_nxt  = 1'b1;
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (!ack_on_r) begin
              ack_on_nxt = 1'b1;
              sda_oe_nxt = 1'b1; // RULE4 RULE11
            end else if (!pend_r) begin
              ack_on_nxt = 1'b0;
              sda_oe_nxt = 1'b0;
              bitcnt_nxt = '0;
              if (kind_r == K_DEV && rw_r) begin
                load_tx = 1'b1; // RULE15
              end else begin
                st_nxt   = ST_RX; // RULE17
                kind_nxt = (kind_r == K_DEV) ? K_REG : K_DATA;
              end
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt_r == BIT_LAST) begin
              st_nxt     = ST_MACK;
              sda_oe_nxt = 1'b0; // RULE11
            end else begin
              tx_sh_nxt  = {tx_sh_r[6:0], 1'b0};
              sda_oe_nxt = ~tx_sh_r[6];
              bitcnt_nxt = bitcnt_r + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_nxt = ST_IDLE; // RULE12 RULE22
            end else begin
              mack_ok_nxt = 1'b1;
              if (inc_en_r) begin
                ptr_nxt = ptr_inc; // RULE16 RULE21
              end
            end
          end else if (scl_fall && mack_ok_r) begin
            mack_ok_nxt = 1'b0;
            bitcnt_nxt  = '0;
            load_tx     = 1'b1; // RULE16
          end
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end
    // first bit goes out on the same falling edge that ends the ack
    if (load_tx) begin
      st_nxt     = ST_TX;
      tx_sh_nxt  = reg_rd_data;
      sda_oe_nxt = ~reg_rd_data[7];
      rd_stb_nxt = 1'b1;
    end
  end

  // straps are caught by the clock while reset is held
  always_ff @(posedge clk) begin
    if (srst) begin
      spi_sel_r  <= mode_s; // RULE1
      addr_sel_r <= addr_s; // RULE2
    end
  end

  // line history, idle bus is high
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  // engine registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r      <= ST_IDLE;
      kind_r    <= K_DEV;
      bitcnt_r  <= '0;
      rx_sh_r   <= '0;
      tx_sh_r   <= '0;
      ptr_r     <= PTR_RESET;
      wbyte_r   <= '0;
      sda_oe_r  <= 1'b0;
      ack_on_r  <= 1'b0;
      rw_r      <= 1'b0;
      inc_en_r  <= 1'b0;
      pend_r    <= 1'b0;
      mack_ok_r <= 1'b0;
      rd_stb_r  <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      kind_r    <= kind_nxt;
      bitcnt_r  <= bitcnt_nxt;
      rx_sh_r   <= rx_sh_nxt;
      tx_sh_r   <= tx_sh_nxt;
      ptr_r     <= ptr_nxt;
      wbyte_r   <= wbyte_nxt;
      sda_oe_r  <= sda_oe_nxt;
      ack_on_r  <= ack_on_nxt;
      rw_r      <= rw_nxt;
      inc_en_r  <= inc_en_nxt;
      pend_r    <= pend_nxt;
      mack_ok_r <= mack_ok_nxt;
      rd_stb_r  <= rd_stb_nxt;
    end
  end

  // pins: open drain, only ever pull low
  // clock is stretched while a full buffer holds the acked byte
  assign scl_value              = 1'b0;
  assign scl_oe                 = pend_r & ack_on_r;
  assign serial_data_line_value = 1'b0;
  assign serial_data_line_oe    = sda_oe_r;
  assign spi_selected           = spi_sel_r;
  assign reg_rd_addr            = ptr_r;
  assign reg_rd_strobe          = rd_stb_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // sync flops carry no reset, so the first reset cycles hold unknowns
  a_strap_latch: assert property (disable iff (1'b0) srst ##1 srst ##1 srst |=> spi_sel_r == $past(mode_s)) // RULE1
    else $error("interface strap not latched in reset");
  a_spi_quiet: assert property (spi_sel_r |-> st_r == ST_IDLE && !sda_oe_r) // RULE1
    else $error("two-wire engine active with spi strapped");
  a_start_enter: assert property (start_det && i2c_on |=> st_r == ST_RX && kind_r == K_DEV && bitcnt_r == 3'h0) // RULE6
    else $error("start not taken");
  a_stop_idle: assert property (stop_det |=> st_r == ST_IDLE && !sda_oe_r) // RULE8
    else $error("stop did not end transfer");
  a_idle_quiet: assert property (st_r == ST_IDLE |-> !sda_oe_r) // RULE7
    else $error("data driven while idle");
  a_nomatch_release: assert property (byte_done && kind_r == K_DEV && !addr_match |=> st_r == ST_IGNORE ##1 !sda_oe_r) // RULE5
    else $error("mismatched address not ignored");
  // bound covers a standard-rate clock high time; slower masters exceed it
  a_match_ack: assert property (byte_done && kind_r == K_DEV && addr_match |-> ##[1:1000] sda_oe_r) // RULE4
    else $error("matching address not acknowledged");
  a_ack_drive: assert property (st_r == ST_ACK && ack_on_r |-> sda_oe_r) // RULE11
    else $error("ack bit not driven");
  a_tx_release: assert property (st_r == ST_MACK |-> !sda_oe_r) // RULE11
    else $error("data held during master ack");
  a_nack_idle: assert property (st_r == ST_MACK && scl_rise && sda_s |=> st_r == ST_IDLE) // RULE22
    else $error("master nack did not end read");
  a_reg_load: assert property (byte_done && kind_r == K_REG |=> ptr_r == $past(rx_byte)) // RULE24
    else $error("register byte did not load pointer");
  a_fixed_ptr: assert property (push && !inc_en_r |=> $stable(ptr_r)) // RULE19
    else $error("pointer moved in fixed range");
  a_ptr_wrap: assert property (push && inc_en_r && ptr_r == LAST_REG_ADDR |=> ptr_r == PTR_WRAP) // RULE21
    else $error("pointer did not wrap");

  c_read_byte: cover property (st_r == ST_MACK && scl_rise && !sda_s);
  c_write_push: cover property (push && inc_en_r);
  c_ignore: cover property (st_r == ST_IGNORE);
  c_stretch: cover property (scl_oe [*3]);

endmodule

// ---- tsi_pkg.sv ----
/*
  Shared constants and types for the touch-expander serial register port:
  bus addresses, strap encodings, timing figures and engine states.
  Assumes a single 125 MHz clock domain inside the port.
*/
//
// Contract
// [RULE1] latch interface strap in reset: 0 two-wire
// [RULE2] answer 0x82 or 0x88 per address strap
// [RULE3] direction bit one reads, zero writes
// [RULE4] matching address is acknowledged in ninth bit
// [RULE5] mismatch releases bus until next start
// [RULE6] start is data falling while clock high
// [RULE7] ignore everything not preceded by start
// [RULE8] stop is data rising while clock high
// [RULE9] stop after unacknowledged read returns idle
// [RULE10] stop ends write, no further writes
// [RULE11] transmitter releases, receiver acknowledges ninth bit
// [RULE12] declining receiver leaves data high
// [RULE13] sample data on each clock rising edge
// [RULE14] master changes data only while clock low
// [RULE15] read: write address, restart, read, stop
// [RULE16] reads continue, pointer advances in range
// [RULE17] write: start, address, register, data, stop
// [RULE18] writes increment only in auto-increment range
// [RULE19] non-incrementing range keeps pointer fixed
// [RULE20] works at 100 and 400 kbit rates
// [RULE21] pointer wraps past last address to zero
// [RULE22] master not acknowledging read ends to idle
// [RULE23] synchronise bus lines, detect edges internally
// [RULE24] first write byte loads the register pointer
package tsi_pkg;

  // bus addresses, 8-bit form with direction bit clear
  localparam logic [7:0] DEV_ADDR_A0   = 8'h82;
  localparam logic [7:0] DEV_ADDR_A1   = 8'h88;
  localparam logic       RW_READ       = 1'b1;
  localparam logic       STRAP_TWOWIRE = 1'b0;

  // register pointer
  localparam int         BYTE_W        = 8;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [7:0] PTR_WRAP      = 8'h00;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // write stream: pointer in the upper byte, data in the lower
  localparam int         WR_WORD_W     = 2 * BYTE_W;
  localparam int         FIFO_DEPTH    = 32;

  // timing
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SCL_STD_KBPS  = 100;
  localparam int         SCL_FAST_KBPS = 400;
  localparam int         T_HIGH_NS     = 600;
  localparam int         T_SU_DAT_NS   = 100;
  localparam int         T_HIGH_CYC    = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         T_SU_DAT_CYC  = (T_SU_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         SYNC_LAT_CYC  = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
  } tsi_state_t;

  typedef enum logic [1:0] {
    K_DEV, K_REG, K_DATA
  } tsi_kind_t;

endpackage

// ---- tsi_stream_if.sv ----
/*
  Valid/ready stream carrying register write words between the
  slave engine and its write buffer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface tsi_stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- tsi_sync.sv ----
/*
  Two-flop synchronisers, one per bit, for pins from outside the clock.
  Assumes inputs are slow levels; no reset so straps pass during reset.
*/
`timescale 1ns/1ps
module tsi_sync #(
  parameter int WIDTH = 4
) (
  // clock
  input  wire logic             clk,
  // asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // a zero-width bank would leave the pins unsampled
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser needs at least one bit");
  end

  logic [WIDTH-1:0] meta_r;

  // first flop feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      meta_r[i] <= din[i];
      dout[i]   <= meta_r[i];
    end
  end

endmodule

// ---- tsi_fifo.sv ----
/*
  Register-write buffer: first-word-fall-through FIFO of WIDTH x DEPTH.
  Assumes DEPTH a power of two; synchronous active-high reset.
*/
`timescale 1ns/1ps
module tsi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // fill and drain sides
  tsi_stream_if.snk  wr_side,
  tsi_stream_if.src  rd_side
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  wire              full;
  wire              empty;
  wire              wr_en;
  wire              rd_en;

  // extra pointer bit tells full from empty
  assign full          = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign empty         = (wp_r == rp_r);
  assign wr_side.ready = ~full;
  assign rd_side.valid = ~empty;
  assign rd_side.data  = mem[rp_r[AW-1:0]];
  assign wr_en         = wr_side.valid & ~full;
  assign rd_en         = rd_side.valid & rd_side.ready;

  // pointers
  always_ff @(posedge clk) begin
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (wr_en) wp_r <= wp_r + 1'b1;
      if (rd_en) rp_r <= rp_r + 1'b1;
    end
  end

  // storage carries no reset to stay a plain memory
  always_ff @(posedge clk) begin
    if (wr_en) mem[wp_r[AW-1:0]] <= wr_side.data;
  end

endmodule

// ---- tsi_host_model.sv ----
/*
  Bus-master model for the two-wire port: start, stop, byte write, byte read.
  Assumes open-drain wires with pull-ups resolved outside; 64 ns bus clock.
*/
`timescale 1ns/1ps
module tsi_host_model (
  // resolved wire levels
  input  wire logic scl_w,
  input  wire logic sda_w,
  // pull-low enables
  output logic      scl_lo,
  output logic      sda_lo
);
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  // release the clock, then wait out any stretch by the slave
  task automatic rise();
    scl_lo = 1'b0;
    wait (scl_w === 1'b1);
  endtask

  // low 40 ns, high 24 ns; sampled late in high to leave slave latency room
  task automatic bit_io(input logic b, output logic s);
    sda_lo = ~b;
    #20;
    rise();
    #24;
    s = sda_w;
    scl_lo = 1'b1;
    #20;
  endtask

  // start or repeated start
  task automatic start();
    sda_lo = 1'b0;
    #20;
    rise();
    #24;
    sda_lo = 1'b1;
    #24;
    scl_lo = 1'b1;
    #20;
  endtask

  task automatic stop();
    sda_lo = 1'b1;
    #20;
    rise();
    #24;
    sda_lo = 1'b0;
    #40;
  endtask

  // clock low without a start, for traffic that must be ignored
  task automatic clk_low();
    scl_lo = 1'b1;
    #20;
  endtask

  // msb first, ninth bit released; ack is 1 when the slave pulled low
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // master acks to continue, leaves the line high to end the read
  task automatic rd_byte(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

// ---- tb_touch_expander_i2c_slave_port.sv ----
/*
  Self-checking bench for the two-wire slave port: table of reads and writes,
  then mismatch, no-start, buffer stall and strap cases.
  Assumes the slave's own assertions run inside the design files.
*/
`timescale 1ns/1ps
module tb_touch_expander_i2c_slave_port;
  import tsi_pkg::*;
  localparam logic [7:0] LAST = 8'h3f;
  localparam logic [7:0] NLO  = 8'h20;
  localparam logic [7:0] NHI  = 8'h2f;
  typedef struct { logic rd; logic [7:0] ra; int n; } tsi_row_t;

  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       mode_strap = 1'b0;
  logic       addr_strap = 1'b0;
  logic       wr_ready = 1'b1;
  logic [7:0] reg_rd_data = 8'h00;
  logic [7:0] dev = DEV_ADDR_A0;
  logic       spi_selected, scl_value, scl_oe, sda_value, sda_oe;
  logic       reg_rd_strobe, wr_valid, scl_lo, sda_lo;
  logic [7:0] reg_rd_addr, wr_addr, wr_data;
  wire logic  scl_w = ~(scl_oe & ~scl_value) & ~scl_lo;
  wire logic  sda_w = ~(sda_oe & ~sda_value) & ~sda_lo;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         n_strobe = 0;
  int         acks;
  logic       a;
  logic [15:0] got[$];
  tsi_row_t   rows[6] = '{'{0, 8'h10, 3}, '{0, 8'h24, 3}, '{0, 8'h3e, 3},
                          '{1, 8'h05, 1}, '{1, 8'h3e, 3}, '{1, 8'h22, 2}};

  always #4 clk = ~clk;

  tsi_i2c_slave #(.LAST_REG_ADDR(LAST), .NOINC_LO(NLO), .NOINC_HI(NHI), .WR_DEPTH(32)) dut_u (
    .clk(clk), .srst(srst), .iface_mode_strap(mode_strap), .bus_address_strap(addr_strap),
    .spi_selected(spi_selected), .scl_level(scl_w), .scl_value(scl_value), .scl_oe(scl_oe),
    .serial_data_line_level(sda_w), .serial_data_line_value(sda_value),
    .serial_data_line_oe(sda_oe), .reg_rd_addr(reg_rd_addr), .reg_rd_strobe(reg_rd_strobe),
    .reg_rd_data(reg_rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data));

  tsi_host_model host_u (.scl_w(scl_w), .sda_w(sda_w), .scl_lo(scl_lo), .sda_lo(sda_lo));

  // register file model: contents are address xor 5a
  always @(negedge clk) reg_rd_data <= reg_rd_addr ^ 8'h5a;

  // write-stream sink, strobe counter and hang guard
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready) got.push_back({wr_addr, wr_data});
    if (reg_rd_strobe === 1'b1) n_strobe++;
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // pointer step: fixed in the no-increment range, wraps after the last address
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic [7:0] ra);
    if (ra >= NLO && ra <= NHI) return p;
    return (p == LAST) ? 8'h00 : p + 8'h01;
  endfunction

  // straps held across the whole reset, idle outputs checked before release
  task automatic do_reset(input logic m, input logic s);
    @(negedge clk);
    srst = 1'b1;
    mode_strap = m;
    addr_strap = s;
    repeat (4) @(negedge clk);
    check({spi_selected, scl_oe, sda_oe, wr_valid, reg_rd_strobe, reg_rd_addr}, {m, 4'h0, 8'h00});
    srst = 1'b0;
    got.delete();
  endtask

  task automatic wr_xfer(input logic [7:0] d, input logic [7:0] ra, input int n, input logic [7:0] d0);
    logic k_ack;
    acks = 0;
    host_u.start();
    host_u.wr_byte(d, k_ack);
    acks += int'(k_ack);
    host_u.wr_byte(ra, k_ack);
    acks += int'(k_ack);
    for (int k = 0; k < n; k++) begin
      host_u.wr_byte(d0 + 8'(k), k_ack);
      acks += int'(k_ack);
    end
    host_u.stop();
    repeat (8) @(negedge clk);
  endtask

  // compare buffered words against the expected pointer walk
  task automatic expect_words(input logic [7:0] ra, input int n, input logic [7:0] d0);
    logic [7:0]  p;
    logic [15:0] w;
    p = ra;
    for (int k = 0; k < n; k++) begin
      w = (got.size() > 0) ? got.pop_front() : 16'hxxxx;
      check(w, {p, d0 + 8'(k)});
      p = nxt(p, ra);
    end
    check(16'(got.size()), 16'h0000);
  endtask

  task automatic rd_xfer(input logic [7:0] ra, input int n);
    logic [7:0] p;
    logic [7:0] b;
    int         s0;
    p = ra;
    s0 = n_strobe;
    host_u.start();
    host_u.wr_byte(dev, a);
    check(16'(a), 16'h0001);
    host_u.wr_byte(ra, a);
    check(16'(a), 16'h0001);
    host_u.start();
    host_u.wr_byte(dev | 8'h01, a);
    check(16'(a), 16'h0001);
    for (int k = 0; k < n; k++) begin
      host_u.rd_byte(k < n - 1, b);
      check(16'(b), 16'(p ^ 8'h5a));
      p = nxt(p, ra);
    end
    host_u.stop();
    repeat (8) @(negedge clk);
    check(16'(n_strobe - s0), 16'(n));
    check(16'(sda_oe), 16'h0000);
  endtask

  initial begin
    do_reset(1'b0, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].rd) begin
        rd_xfer(rows[i].ra, rows[i].n);
      end else begin
        wr_xfer(dev, rows[i].ra, rows[i].n, 8'(8'h80 + 16 * i));
        check(16'(acks), 16'(rows[i].n + 2));
        expect_words(rows[i].ra, rows[i].n, 8'(8'h80 + 16 * i));
      end
    end
    // other address, with our own address hidden in the payload
    wr_xfer(DEV_ADDR_A1, DEV_ADDR_A0, 2, 8'h11);
    check(16'(acks), 16'h0000);
    check(16'(got.size()), 16'h0000);
    // traffic after a stop with no new start
    host_u.clk_low();
    host_u.wr_byte(dev, a);
    check(16'(a), 16'h0000);
    host_u.wr_byte(8'h01, a);
    host_u.wr_byte(8'h33, a);
    host_u.stop();
    check(16'(got.size()), 16'h0000);
    // consumer stalls past 32 words; slave must stretch, then drain in order
    @(negedge clk);
    wr_ready = 1'b0;
    fork
      wr_xfer(dev, 8'h00, 34, 8'h40);
      begin
        repeat (3000) @(negedge clk);
        check({scl_oe, wr_valid}, 16'h0003);
        wr_ready = 1'b1;
      end
    join
    check(16'(acks), 16'd36);
    expect_words(8'h00, 34, 8'h40);
    // second bus address
    do_reset(1'b0, 1'b1);
    dev = DEV_ADDR_A1;
    wr_xfer(DEV_ADDR_A0, 8'h01, 1, 8'h77);
    check(16'(acks), 16'h0000);
    wr_xfer(dev, 8'h01, 1, 8'h77);
    check(16'(acks), 16'h0003);
    expect_words(8'h01, 1, 8'h77);
    // serial-peripheral strap: two-wire port stays silent
    do_reset(1'b1, 1'b0);
    wr_xfer(DEV_ADDR_A0, 8'h01, 1, 8'h66);
    check(16'(acks), 16'h0000);
    check(16'(got.size()), 16'h0000);
    end_sim();
  end
endmodule
